// ===== verilog/pbw_pkg.sv
// Holds the shared constants of the power button and wake sequencer.
// Assumes a 10 MHz always-on standby clock; counts derive from it.
package pbw_pkg;

  // System power states, kept in standby logic
  typedef enum logic [2:0] {
    PBW_WORK,
    PBW_S3,
    PBW_S4,
    PBW_S5,
    PBW_G3
  } pbw_state_e;

  // Clock period of the standby clock
  localparam longint unsigned CLK_PERIOD_NS = 64'd100;
  localparam longint unsigned NS_PER_MS     = 64'd1000000;

  // Long press threshold and contact debounce time, in milliseconds
  localparam longint unsigned LONG_PRESS_MS = 64'd4000;
  localparam longint unsigned DEBOUNCE_MS   = 64'd10;

  // Cycle counts derived from the times; long press exact means long
  localparam longint unsigned LONG_PRESS_CYC = (LONG_PRESS_MS * NS_PER_MS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
  localparam longint unsigned DEBOUNCE_CYC   = (DEBOUNCE_MS * NS_PER_MS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

  // Width of the press and debounce counters; holds 40,000,000
  localparam int unsigned CNT_W = 26;

  // Counter start value
  localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 26'h0000001;

endpackage

// ===== verilog/pbw_sequencer.sv
// Holds the power state sequencer: switch timing, wake gating, power enables.
// Assumes all inputs are synchronous to core_clk and that core_clk and
// sys_rst live on standby power; sleep requests come from the OS side.
//
// Function
// - From soft-off, short press then release powers system on to working.
// - In working, short press gives soft-off; long press forces fail-safe soft-off.
// - In sleep, short press wakes to working; long press goes to soft-off.
// - Switch, RTC, LAN, PCIe wake and PME wake from S3, S4 and S5.
// - USB and serial wake only from S3; USB unpowered in S4 and S5.
// - PS/2 wakes S3, S4, S5; a setting limits S4 and S5 wake to special keys.
// - Leaving S5 is a cold boot; S3 resumes from RAM, S4 from disk.
// - Five states; non-working states cut main power, wake logic keeps standby except in G3.
`timescale 1ns/10ps

module pbw_sequencer
  import pbw_pkg::*;
#(
  parameter longint unsigned LONG_CYC = LONG_PRESS_CYC,
  parameter longint unsigned DEB_CYC  = DEBOUNCE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       pwr_sw_n,
  input  wire logic       standby_ok,
  input  wire logic       rtc_alarm,
  input  wire logic       lan_wake,
  input  wire logic       pcie_wake_n,
  input  wire logic       pci_pme_n,
  input  wire logic       usb_wake,
  input  wire logic       serial_wake,
  input  wire logic       ps2_wake,
  input  wire logic       ps2_special_key,
  input  wire logic       ps2_s5_combo_only,
  input  wire logic       sleep_req,
  input  wire logic       sleep_to_disk,
  input  wire logic       soft_off_req,
  output pbw_state_e      sys_state,
  output logic            main_pwr_en,
  output logic            usb_pwr_en,
  output logic            wake_pwr_en,
  output logic            cold_boot,
  output logic            resume_ram,
  output logic            resume_disk
);

  // ****************************************************************
  // Switch debounce and press timing
  // ****************************************************************

  pbw_state_e       state;
  pbw_state_e       next_state;
  logic [CNT_W-1:0] deb_cnt;
  logic             deb_pressed;
  logic             deb_prev;
  logic [CNT_W-1:0] press_cnt;
  logic             long_done;

  wire logic raw_pressed = ~pwr_sw_n;
  wire logic raw_differs = raw_pressed != deb_pressed;
  wire logic deb_settled = raw_differs && (deb_cnt == CNT_W'(DEB_CYC - 64'd1));
  wire logic long_hit    = deb_pressed && !long_done && (press_cnt == CNT_W'(LONG_CYC - 64'd1));
  wire logic released    = deb_prev && !deb_pressed;
  wire logic short_rel   = released && !long_done;
  wire logic press_sat   = press_cnt == CNT_W'(LONG_CYC - 64'd1);

  // Level must hold for the whole debounce time before it is believed
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deb_cnt     <= CNT_ZERO;
      deb_pressed <= 1'b0;
      deb_prev    <= 1'b0;
    end else begin
      deb_cnt     <= (raw_differs && !deb_settled) ? deb_cnt + CNT_ONE : CNT_ZERO;
      deb_pressed <= deb_settled ? raw_pressed : deb_pressed;
      deb_prev    <= deb_pressed;
    end
  end

  // Press counter saturates so a held switch never wraps to a short press
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      press_cnt <= CNT_ZERO;
      long_done <= 1'b0;
    end else begin
      press_cnt <= !deb_pressed ? CNT_ZERO : (press_sat ? press_cnt : press_cnt + CNT_ONE);
      long_done <= long_hit ? 1'b1 : (released ? 1'b0 : long_done);
    end
  end

  // ****************************************************************
  // Wake source gating
  // ****************************************************************

  wire logic sleeping  = (state == PBW_S3) || (state == PBW_S4) || (state == PBW_S5);
  wire logic in_s3     = state == PBW_S3;
  // No disk context is kept here; S4 is treated like S5 for gating
  wire logic deep      = (state == PBW_S4) || (state == PBW_S5);
  wire logic wake_ext  = rtc_alarm || lan_wake || !pcie_wake_n || !pci_pme_n;
  wire logic wake_s3   = in_s3 && (usb_wake || serial_wake);
  // Deep sleep PS/2 wake can be held to combination or power key only
  wire logic ps2_ok    = ps2_wake && (!deep || !ps2_s5_combo_only || ps2_special_key);
  wire logic wake_any  = sleeping && (wake_ext || wake_s3 || ps2_ok || short_rel);

  // ****************************************************************
  // State sequencing
  // ****************************************************************

  // Standby loss wins, then the forced long press, then wake and OS requests
  always_comb begin
    next_state = state;
    if (!standby_ok) begin
      next_state = PBW_G3;
    end else begin
      case (state)
        PBW_G3: begin
          next_state = PBW_S5;
        end
        PBW_WORK: begin
          if (long_hit || short_rel || soft_off_req) begin
            next_state = PBW_S5;
          end else if (sleep_req) begin
            next_state = sleep_to_disk ? PBW_S4 : PBW_S3;
          end
        end
        PBW_S3, PBW_S4: begin
          if (long_hit) begin
            next_state = PBW_S5;
          end else if (wake_any) begin
            next_state = PBW_WORK;
          end
        end
        PBW_S5: begin
          // A long press here is ignored; only a short release or wake boots
          if (wake_any) begin
            next_state = PBW_WORK;
          end
        end
        default: begin
          next_state = PBW_S5;
        end
      endcase
    end
  end

  wire logic next_main = next_state == PBW_WORK;
  wire logic next_usb  = (next_state == PBW_WORK) || (next_state == PBW_S3);
  wire logic next_wake = next_state != PBW_G3;
  wire logic to_work   = next_main && (state != PBW_WORK);

  // Enables and resume pulses are registered beside the state itself
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state       <= PBW_S5;
      main_pwr_en <= 1'b0;
      usb_pwr_en  <= 1'b0;
      wake_pwr_en <= 1'b1;
      cold_boot   <= 1'b0;
      resume_ram  <= 1'b0;
      resume_disk <= 1'b0;
    end else begin
      state       <= next_state;
      main_pwr_en <= next_main;
      usb_pwr_en  <= next_usb;
      wake_pwr_en <= next_wake;
      cold_boot   <= to_work && (state == PBW_S5);
      resume_ram  <= to_work && (state == PBW_S3);
      resume_disk <= to_work && (state == PBW_S4);
    end
  end

  assign sys_state = state;

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence seq_short_rel;
    standby_ok && short_rel;
  endsequence

  sequence seq_long_hit;
    standby_ok && long_hit;
  endsequence

  chk_soft_off_boot: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PBW_S5) ##0 seq_short_rel |=> (state == PBW_WORK) && main_pwr_en)
    else $error("short press in soft-off did not power on");

  chk_work_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PBW_WORK) ##0 (seq_short_rel or seq_long_hit) |=> (state == PBW_S5) && !main_pwr_en)
    else $error("press in working did not reach soft-off");

  chk_sleep_press: assert property (@(posedge core_clk) disable iff (sys_rst)
    (in_s3 || state == PBW_S4) ##0 seq_long_hit |=> state == PBW_S5)
    else $error("long press in sleep did not reach soft-off");

  chk_sleep_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    sleeping && standby_ok && !long_hit && (wake_ext || short_rel) |=> state == PBW_WORK)
    else $error("enabled wake source did not wake the system");

  chk_usb_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    usb_pwr_en |-> (state == PBW_WORK) || (state == PBW_S3))
    else $error("usb powered outside working or S3");

  chk_ps2_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PBW_S5) && ps2_s5_combo_only && !ps2_special_key && !wake_ext && !short_rel
      |=> state != PBW_WORK)
    else $error("plain ps2 activity woke from soft-off");

  chk_resume_kind: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == PBW_S5) ##1 (state == PBW_WORK) |-> cold_boot && !resume_ram && !resume_disk)
    else $error("leaving soft-off was not a cold boot");

  chk_power_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !standby_ok |=> (state == PBW_G3) && !wake_pwr_en && !main_pwr_en)
    else $error("standby loss did not reach mechanical off");

  chk_long_exact: assert property (@(posedge core_clk) disable iff (sys_rst)
    deb_pressed && $rose(long_done) |-> $past(press_cnt) == CNT_W'(LONG_CYC - 64'd1))
    else $error("long press flagged at wrong count");

endmodule

// ===== tb/pbw_switch_model.sv
// Holds a front panel power switch model for the sequencer bench.
// Assumes the bench calls press from its own thread; the contact moves on falling edges.
`timescale 1ns/10ps
module pbw_switch_model (
  input  wire logic core_clk,
  output logic      pwr_sw_n
);
  // The pull-up holds the contact open between presses
  initial pwr_sw_n = 1'b1;
  // Close the contact for n cycles; no bounce, so debounce delay is the only lag
  task automatic press(input int n);
    @(negedge core_clk);
    pwr_sw_n = 1'b0;
    repeat (n) @(negedge core_clk);
    pwr_sw_n = 1'b1;
  endtask
endmodule

// ===== tb/tb_pbw_sequencer.sv
// Holds the self-checking bench of the power button and wake sequencer.
// Assumes short counts LONG_CYC=64 and DEB_CYC=4; inputs move on falling edges.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_pbw_sequencer
  import pbw_pkg::*;
;
  localparam int LC = 64;
  localparam int DC = 4;
  logic core_clk, sys_rst, standby_ok, rtc_alarm, lan_wake, pcie_wake_n, pci_pme_n, usb_wake, serial_wake;
  logic pwr_sw_n, ps2_wake, ps2_special_key, ps2_s5_combo_only, sleep_req, sleep_to_disk, soft_off_req;
  logic main_pwr_en, usb_pwr_en, wake_pwr_en, cold_boot, resume_ram, resume_disk;
  pbw_state_e sys_state;
  logic [2:0] seen;
  int         errors, tests_run;
  pbw_sequencer #(.LONG_CYC(LC), .DEB_CYC(DC)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .pwr_sw_n(pwr_sw_n), .standby_ok(standby_ok),
    .rtc_alarm(rtc_alarm), .lan_wake(lan_wake), .pcie_wake_n(pcie_wake_n), .pci_pme_n(pci_pme_n),
    .usb_wake(usb_wake), .serial_wake(serial_wake), .ps2_wake(ps2_wake), .ps2_special_key(ps2_special_key),
    .ps2_s5_combo_only(ps2_s5_combo_only), .sleep_req(sleep_req), .sleep_to_disk(sleep_to_disk),
    .soft_off_req(soft_off_req), .sys_state(sys_state), .main_pwr_en(main_pwr_en), .usb_pwr_en(usb_pwr_en),
    .wake_pwr_en(wake_pwr_en), .cold_boot(cold_boot), .resume_ram(resume_ram), .resume_disk(resume_disk));
  pbw_switch_model u_sw (.core_clk(core_clk), .pwr_sw_n(pwr_sw_n));
  // Free running standby clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Bounded wait for a state; one-cycle pulses are gathered on the way
  task automatic wait_for(input pbw_state_e s, input int max);
    seen = 3'h0;
    for (int i = 0; i < max && sys_state !== s; i++) begin
      @(negedge core_clk);
      seen = seen | {cold_boot, resume_ram, resume_disk};
    end
  endtask
  task automatic chk_st(input pbw_state_e s, input logic [2:0] p, input logic m, input logic u);
    `CHK("sys_state", s, sys_state)
    `CHK("pulses", p, seen)
    `CHK("main_pwr_en", m, main_pwr_en)
    `CHK("usb_pwr_en", u, usb_pwr_en)
  endtask
  // OS request held for one cycle
  task automatic os_req(input logic disk, input logic off);
    @(negedge core_clk);
    sleep_req = ~off;
    sleep_to_disk = disk;
    soft_off_req = off;
    @(negedge core_clk);
    sleep_req = 1'b0;
    soft_off_req = 1'b0;
  endtask
  // Index picks RTC, LAN, PCIe wake, PME, PS/2 special key, plain PS/2 key
  task automatic set_src(input int k, input logic on);
    rtc_alarm = on && k == 0;
    lan_wake = on && k == 1;
    pcie_wake_n = !(on && k == 2);
    pci_pme_n = !(on && k == 3);
    ps2_wake = on && k >= 4;
    ps2_special_key = on && k == 4;
  endtask
  // Soft-off after reset, wake logic powered, short press gives a cold boot
  task automatic t_cold_boot();
    `CHK("wake_pwr_en", 1'b1, wake_pwr_en)
    u_sw.press(20);
    wait_for(PBW_WORK, 40);
    chk_st(PBW_WORK, 3'h4, 1'b1, 1'b1);
    $display("test cold_boot done");
  endtask
  // USB, serial, then a plain PS/2 key resume from RAM; the key limit spares S3
  task automatic t_wake_s3();
    ps2_s5_combo_only = 1'b1;
    for (int k = 0; k < 3; k++) begin
      os_req(1'b0, 1'b0);
      wait_for(PBW_S3, 5);
      chk_st(PBW_S3, 3'h0, 1'b0, 1'b1);
      usb_wake = k == 0;
      serial_wake = k == 1;
      ps2_wake = k == 2;
      wait_for(PBW_WORK, 5);
      usb_wake = 1'b0;
      serial_wake = 1'b0;
      ps2_wake = 1'b0;
      chk_st(PBW_WORK, 3'h2, 1'b1, 1'b1);
    end
    $display("test wake_s3 done");
  endtask
  // In S4 USB, serial and plain PS/2 keys are refused; the special key wakes
  task automatic t_s4_gate();
    os_req(1'b1, 1'b0);
    wait_for(PBW_S4, 5);
    chk_st(PBW_S4, 3'h0, 1'b0, 1'b0);
    usb_wake = 1'b1;
    serial_wake = 1'b1;
    ps2_wake = 1'b1;
    ps2_s5_combo_only = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHK("sys_state", PBW_S4, sys_state)
    usb_wake = 1'b0;
    serial_wake = 1'b0;
    ps2_special_key = 1'b1;
    wait_for(PBW_WORK, 5);
    set_src(0, 1'b0);
    chk_st(PBW_WORK, 3'h1, 1'b1, 1'b1);
    $display("test s4_gate done");
  endtask
  // Each always-on source wakes S5; USB, serial and a plain key under the limit do not
  task automatic t_s5_sources();
    for (int k = 0; k < 6; k++) begin
      ps2_s5_combo_only = k != 5;
      os_req(1'b0, 1'b1);
      wait_for(PBW_S5, 5);
      chk_st(PBW_S5, 3'h0, 1'b0, 1'b0);
      if (k == 0) begin
        usb_wake = 1'b1;
        serial_wake = 1'b1;
        ps2_wake = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK("sys_state", PBW_S5, sys_state)
        usb_wake = 1'b0;
        serial_wake = 1'b0;
        ps2_wake = 1'b0;
      end
      set_src(k, 1'b1);
      wait_for(PBW_WORK, 5);
      set_src(k, 1'b0);
      chk_st(PBW_WORK, 3'h4, 1'b1, 1'b1);
    end
    $display("test s5_sources done");
  endtask
  // Short and long presses from work and from sleep
  task automatic t_switch();
    u_sw.press(20);
    wait_for(PBW_S5, 40);
    chk_st(PBW_S5, 3'h0, 1'b0, 1'b0);
    u_sw.press(20);
    wait_for(PBW_WORK, 40);
    fork u_sw.press(100); join_none
    wait_for(PBW_S5, LC + DC + 4);
    `CHK("sys_state", PBW_S5, sys_state)
    repeat (110) @(negedge core_clk);
    `CHK("sys_state", PBW_S5, sys_state)
    u_sw.press(20);
    wait_for(PBW_WORK, 40);
    os_req(1'b0, 1'b0);
    u_sw.press(20);
    wait_for(PBW_WORK, 40);
    chk_st(PBW_WORK, 3'h2, 1'b1, 1'b1);
    os_req(1'b0, 1'b0);
    u_sw.press(100);
    `CHK("sys_state", PBW_S5, sys_state)
    $display("test switch done");
  endtask
  // Standby loss gives mechanical off; its return gives soft-off
  task automatic t_standby();
    standby_ok = 1'b0;
    wait_for(PBW_G3, 3);
    chk_st(PBW_G3, 3'h0, 1'b0, 1'b0);
    `CHK("wake_pwr_en", 1'b0, wake_pwr_en)
    standby_ok = 1'b1;
    wait_for(PBW_S5, 3);
    `CHK("sys_state", PBW_S5, sys_state)
    $display("test standby done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: quiet inputs, four reset cycles, then the tests
  initial begin
    sys_rst = 1'b1;
    standby_ok = 1'b1;
    usb_wake = 1'b0;
    serial_wake = 1'b0;
    ps2_s5_combo_only = 1'b0;
    sleep_req = 1'b0;
    sleep_to_disk = 1'b0;
    soft_off_req = 1'b0;
    set_src(0, 1'b0);
    // Four rising edges fall inside reset before release on a falling edge
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    t_cold_boot();
    t_wake_s3();
    t_s4_gate();
    t_s5_sources();
    t_switch();
    t_standby();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
endmodule
